// *** shared/zc_capture_pkg.sv ***
package zc_capture_pkg;

    localparam int CNT_W  = 16;
    localparam int TRIP_N = 8;
    localparam int SEL_W  = 3;
    localparam int ADDR_W = 12;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] CROSSBAR_EN_OFS   = 12'h000;
    localparam logic [ADDR_W-1:0] COMPARE_SEL_OFS   = 12'h004;
    localparam logic [ADDR_W-1:0] COMPARE_CTRL_OFS  = 12'h008;
    localparam logic [ADDR_W-1:0] FILTER_CTRL_OFS   = 12'h00C;
    localparam logic [ADDR_W-1:0] BLANK_OFFSET_OFS  = 12'h010;
    localparam logic [ADDR_W-1:0] BLANK_LENGTH_OFS  = 12'h014;
    localparam logic [ADDR_W-1:0] VALLEY_CTRL_OFS   = 12'h018;
    localparam logic [ADDR_W-1:0] SW_DELAY_OFS      = 12'h01C;
    localparam logic [ADDR_W-1:0] CAPTURE_OFS       = 12'h020;
    localparam logic [ADDR_W-1:0] TIME_BASE_CTL_OFS = 12'h024;
    localparam logic [ADDR_W-1:0] PHASE_OFS         = 12'h028;
    localparam logic [ADDR_W-1:0] PERIOD_OFS        = 12'h02C;
    localparam logic [ADDR_W-1:0] STATUS_OFS        = 12'h030;

    // Field positions
    localparam int COND_LSB       = 4;
    localparam int SYNC_SRC_BIT   = 0;
    localparam int SYNC_EN_BIT    = 1;
    localparam int BLANK_EN_BIT   = 1;
    localparam int TRIG_SEL_BIT   = 0;
    localparam int SW_START_BIT   = 1;
    localparam int DELAY_SEL_BIT  = 2;

    // Event condition codes
    localparam logic [1:0] COND_OFF  = 2'h0;
    localparam logic [1:0] COND_LOW  = 2'h1;
    localparam logic [1:0] COND_HIGH = 2'h2;

    // Values after reset
    localparam logic [CNT_W-1:0] PERIOD_RST = 16'hFFFF;
    localparam logic [CNT_W-1:0] ZERO_CNT   = 16'h0000;

    typedef enum logic [2:0] {
        FILT_IDLE  = 3'h1,
        FILT_ARMED = 3'h2,
        FILT_DELAY = 3'h4
    } filt_state_type;

    typedef struct packed {
        logic             delay_en;
        logic [CNT_W-1:0] delay_val;
    } delay_cfg_type;

    typedef struct packed {
        logic             enable;
        logic [CNT_W-1:0] offset;
        logic [CNT_W-1:0] length;
    } blank_cfg_type;

endpackage

// *** logic/valley_edge_filter.sv ***
`timescale 1ns/1ps
module valley_edge_filter
    import zc_capture_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             event_in,
    input  wire logic             rearm,
    input  wire delay_cfg_type    dly,
    input  wire logic [CNT_W-1:0] count_in,
    output logic                  filt_pulse_q,
    output logic [CNT_W-1:0]      capture_q,
    output logic                  armed_q
);

    filt_state_type   state_q;
    logic             event_prev_q;
    logic [CNT_W-1:0] delay_cnt_q;
    logic             rise;
    logic             take;

    assign rise = event_in & ~event_prev_q;
    // A re-arm in the same cycle as an edge discards the edge
    assign take = (state_q == FILT_ARMED) & rise & ~rearm;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            event_prev_q <= 1'b0;
        else
            event_prev_q <= event_in;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            state_q <= FILT_IDLE;
        else if (rearm)
            state_q <= FILT_ARMED;
        else
        begin
            unique case (state_q)
                FILT_IDLE:
                    state_q <= FILT_IDLE;
                FILT_ARMED:
                    if (rise)
                        state_q <= (dly.delay_en && dly.delay_val != ZERO_CNT)
                                   ? FILT_DELAY : FILT_IDLE;
                FILT_DELAY:
                    if (delay_cnt_q == 16'h0001)
                        state_q <= FILT_IDLE;
                default:
                    state_q <= FILT_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            delay_cnt_q <= ZERO_CNT;
        else if (take)
            delay_cnt_q <= dly.delay_val;
        else if (state_q == FILT_DELAY)
            delay_cnt_q <= delay_cnt_q - 16'h0001;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            filt_pulse_q <= 1'b0;
        else if (take)
            filt_pulse_q <= ~(dly.delay_en && dly.delay_val != ZERO_CNT);
        else
            filt_pulse_q <= (state_q == FILT_DELAY)
                            && (delay_cnt_q == 16'h0001) && !rearm;
    end

    // Counter is taken at the edge itself, so the delay does not skew it
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            capture_q <= ZERO_CNT;
        else if (take)
            capture_q <= count_in;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            armed_q <= 1'b0;
        else
            armed_q <= rearm | (state_q == FILT_ARMED & ~rise);
    end

    pulse_width_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        filt_pulse_q |=> !filt_pulse_q)
        else $error("filtered event wider than one clock");

    capture_value_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        take |=> capture_q == $past(count_in))
        else $error("capture missed the counter value");

    single_capture_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (state_q == FILT_IDLE) && !rearm |=> $stable(capture_q))
        else $error("capture while not armed");

    delay_end_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        take && dly.delay_en && dly.delay_val > 16'h0001
        |=> !filt_pulse_q ##0 (state_q == FILT_DELAY))
        else $error("software delay not applied");

    rearm_state_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        rearm |=> state_q == FILT_ARMED && armed_q)
        else $error("trigger did not restart filter");

endmodule

// *** logic/time_base_unit.sv ***
`timescale 1ns/1ps
module time_base_unit
    import zc_capture_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic [CNT_W-1:0] period,
    input  wire logic [CNT_W-1:0] phase,
    input  wire logic             load_req,
    output logic [CNT_W-1:0]      count_q
);

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            count_q <= ZERO_CNT;
        else if (load_req)
            count_q <= phase;
        else if (count_q >= period)
            count_q <= ZERO_CNT;
        else
            count_q <= count_q + 16'h0001;
    end

    load_phase_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        load_req |=> count_q == $past(phase))
        else $error("phase value not loaded");

endmodule

// *** logic/zero_cross_capture.sv ***
`timescale 1ns/1ps

// Operation
// - Crossbar passes a trip input only when its mux enable is set.
// - Compare-A-high signal comes from the trip input chosen by its select.
// - Condition select decides when compare-A-high raises the first event.
// - Sync variant may come from the filtered event instead of raw.
// - Sync variant of the first event makes a time-base sync pulse.
// - Edge filter captures the time-base count for software as period.
// - Filter input is the selected event ANDed with the inverted blanking window.
// - Blanking removes noise and the positive crossing, keeping the negative.
// - Filter source select picks raw compare-A-high (set) or the first event (clear) as filter input.
// - With software trigger selected, a software start re-arms the filter.
// - With software delay selected, the filtered event waits the set count.
// - The captured count belongs to the negative crossing, the period.
// - The sync variant reaches sync logic only when sync enable set.
// - Time base obeys sync pulses only when phase load enable set.
// - Each filtered event is exactly one clock wide.
module zero_cross_capture
    import zc_capture_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [TRIP_N-1:0]   crossbar_trip_in,
    output logic                     sync_pulse,
    output logic                     filtered_event,
    output logic      [CNT_W-1:0]    time_base_counter
);

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [TRIP_N-1:0] crossbar_trip_input_mux_enable_q;
    logic [SEL_W-1:0]  compare_a_high_input_select_q;
    logic [1:0]        compare_event_condition_select_q;
    logic              sync_from_filter_q;
    logic              event_one_sync_enable_q;
    logic              filter_source_select_q;
    blank_cfg_type     blank_q;
    logic              valley_trigger_select_q;
    delay_cfg_type     delay_q;
    logic              phase_load_enable_q;
    logic [CNT_W-1:0]  phase_q;
    logic [CNT_W-1:0]  period_q;
    logic              sw_start_q;

    logic              wr_en;
    logic              mapped;
    logic [31:0]       rd_d;

    logic [TRIP_N-1:0] gated_trips;
    logic              compare_a_high_signal;
    logic              first_compare_a_event;
    logic              first_compare_a_event_sync;
    logic [CNT_W:0]    blank_end;
    logic              blank_active;
    logic              filter_in;
    logic              rearm;
    logic              filt_pulse;
    logic [CNT_W-1:0]  capture;
    logic              armed;
    logic [CNT_W-1:0]  tb_count;
    logic              sync_pulse_q;

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, answer registered in the setup cycle
    assign wr_en = psel & penable & pwrite & pready;

    always_comb
    begin
        mapped = 1'b1;
        rd_d   = 32'h0000_0000;
        unique case (paddr)
            CROSSBAR_EN_OFS:
                rd_d[TRIP_N-1:0] = crossbar_trip_input_mux_enable_q;
            COMPARE_SEL_OFS:
            begin
                rd_d[SEL_W-1:0] = compare_a_high_input_select_q;
                rd_d[COND_LSB+1:COND_LSB] = compare_event_condition_select_q;
            end
            COMPARE_CTRL_OFS:
            begin
                rd_d[SYNC_SRC_BIT] = sync_from_filter_q;
                rd_d[SYNC_EN_BIT]  = event_one_sync_enable_q;
            end
            FILTER_CTRL_OFS:
            begin
                rd_d[0]            = filter_source_select_q;
                rd_d[BLANK_EN_BIT] = blank_q.enable;
            end
            BLANK_OFFSET_OFS:
                rd_d[CNT_W-1:0] = blank_q.offset;
            BLANK_LENGTH_OFS:
                rd_d[CNT_W-1:0] = blank_q.length;
            VALLEY_CTRL_OFS:
            begin
                rd_d[TRIG_SEL_BIT]  = valley_trigger_select_q;
                rd_d[DELAY_SEL_BIT] = delay_q.delay_en;
            end
            SW_DELAY_OFS:
                rd_d[CNT_W-1:0] = delay_q.delay_val;
            CAPTURE_OFS:
                rd_d[CNT_W-1:0] = capture;
            TIME_BASE_CTL_OFS:
                rd_d[0] = phase_load_enable_q;
            PHASE_OFS:
                rd_d[CNT_W-1:0] = phase_q;
            PERIOD_OFS:
                rd_d[CNT_W-1:0] = period_q;
            STATUS_OFS:
                rd_d[0] = armed;
            default:
                mapped = 1'b0;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (psel && !penable && !pwrite)
                prdata <= rd_d;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            crossbar_trip_input_mux_enable_q <= '0;
            compare_a_high_input_select_q    <= '0;
            compare_event_condition_select_q <= COND_OFF;
            sync_from_filter_q               <= 1'b0;
            event_one_sync_enable_q          <= 1'b0;
            filter_source_select_q           <= 1'b0;
            blank_q                          <= '0;
            valley_trigger_select_q          <= 1'b0;
            delay_q                          <= '0;
            phase_load_enable_q              <= 1'b0;
            phase_q                          <= ZERO_CNT;
            period_q                         <= PERIOD_RST;
        end
        else if (wr_en)
        begin
            unique case (paddr)
                CROSSBAR_EN_OFS:
                    crossbar_trip_input_mux_enable_q <= pwdata[TRIP_N-1:0];
                COMPARE_SEL_OFS:
                begin
                    compare_a_high_input_select_q <= pwdata[SEL_W-1:0];
                    compare_event_condition_select_q <=
                        pwdata[COND_LSB+1:COND_LSB];
                end
                COMPARE_CTRL_OFS:
                begin
                    sync_from_filter_q      <= pwdata[SYNC_SRC_BIT];
                    event_one_sync_enable_q <= pwdata[SYNC_EN_BIT];
                end
                FILTER_CTRL_OFS:
                begin
                    filter_source_select_q <= pwdata[0];
                    blank_q.enable         <= pwdata[BLANK_EN_BIT];
                end
                BLANK_OFFSET_OFS:
                    blank_q.offset <= pwdata[CNT_W-1:0];
                BLANK_LENGTH_OFS:
                    blank_q.length <= pwdata[CNT_W-1:0];
                VALLEY_CTRL_OFS:
                begin
                    valley_trigger_select_q <= pwdata[TRIG_SEL_BIT];
                    delay_q.delay_en        <= pwdata[DELAY_SEL_BIT];
                end
                SW_DELAY_OFS:
                    delay_q.delay_val <= pwdata[CNT_W-1:0];
                TIME_BASE_CTL_OFS:
                    phase_load_enable_q <= pwdata[0];
                PHASE_OFS:
                    phase_q <= pwdata[CNT_W-1:0];
                PERIOD_OFS:
                    period_q <= pwdata[CNT_W-1:0];
                default:
                    ;
            endcase
        end
    end

    // Start bit is write-only; it reads back as zero
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            sw_start_q <= 1'b0;
        else
            sw_start_q <= wr_en && paddr == VALLEY_CTRL_OFS
                          && pwdata[SW_START_BIT];
    end

    ////////////////////////////////////////////////////////////////////////
    // Trip routing and event qualification
    assign gated_trips = crossbar_trip_in
                         & crossbar_trip_input_mux_enable_q;
    // Trip pins arrive unsynchronised; treated as clock-aligned here
    assign compare_a_high_signal =
        gated_trips[compare_a_high_input_select_q];

    always_comb
    begin
        unique case (compare_event_condition_select_q)
            COND_LOW:
                first_compare_a_event = ~compare_a_high_signal;
            COND_HIGH:
                first_compare_a_event = compare_a_high_signal;
            default:
                first_compare_a_event = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Blanking window, counted from time-base zero
    assign blank_end = {1'b0, blank_q.offset} + {1'b0, blank_q.length};
    // Too short a window lets the positive crossing through
    assign blank_active = blank_q.enable
                          && {1'b0, tb_count} >= {1'b0, blank_q.offset}
                          && {1'b0, tb_count} < blank_end;
    assign filter_in = (filter_source_select_q ? compare_a_high_signal
                                               : first_compare_a_event)
                       & ~blank_active;

    assign rearm = valley_trigger_select_q ? (tb_count == ZERO_CNT)
                                           : sw_start_q;

    valley_edge_filter u_filter (
        .mclk         (mclk),
        .sys_rst      (sys_rst),
        .event_in     (filter_in),
        .rearm        (rearm),
        .dly          (delay_q),
        .count_in     (tb_count),
        .filt_pulse_q (filt_pulse),
        .capture_q    (capture),
        .armed_q      (armed)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sync path into the time base
    assign first_compare_a_event_sync = sync_from_filter_q ? filt_pulse
                                        : first_compare_a_event;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            sync_pulse_q <= 1'b0;
        else
            sync_pulse_q <= first_compare_a_event_sync
                            & event_one_sync_enable_q;
    end

    time_base_unit u_time_base (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .period   (period_q),
        .phase    (phase_q),
        .load_req (sync_pulse_q & phase_load_enable_q),
        .count_q  (tb_count)
    );

    assign sync_pulse        = sync_pulse_q;
    assign filtered_event    = filt_pulse;
    assign time_base_counter = tb_count;

    ////////////////////////////////////////////////////////////////////////
    sync_gate_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        sync_pulse_q |-> $past(event_one_sync_enable_q))
        else $error("sync pulse while sync disabled");

    filtered_sync_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        sync_from_filter_q && event_one_sync_enable_q && filt_pulse
        |=> sync_pulse_q)
        else $error("filtered event gave no sync");

    phase_hold_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        sync_pulse_q && !phase_load_enable_q && tb_count < period_q
        |=> tb_count == $past(tb_count) + 16'h0001)
        else $error("sync obeyed without phase enable");

    phase_load_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        sync_pulse_q && phase_load_enable_q |=> tb_count == $past(phase_q))
        else $error("enabled sync did not load phase");

    blank_block_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        blank_q.enable && tb_count >= blank_q.offset
        && tb_count - blank_q.offset < blank_q.length |-> !filter_in)
        else $error("event passed inside blanking");

    trip_route_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !crossbar_trip_input_mux_enable_q[compare_a_high_input_select_q]
        |-> !compare_a_high_signal)
        else $error("disabled crossbar input passed");

    event_cond_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        compare_event_condition_select_q == COND_OFF
        |-> !first_compare_a_event)
        else $error("event raised with condition off");

    apb_answer_a: assert property (
        @(posedge mclk) disable iff (sys_rst)
        psel && !penable |=> pready)
        else $error("no answer after setup cycle");

endmodule

// *** test/comparator_model.sv ***
`timescale 1ns/1ps
module comparator_model
    import zc_capture_pkg::*;
#(
    parameter logic signed [15:0] ZC_LEVEL = 16'sh0004,
    parameter int                 TRIP_BIT = 5
)
(
    input  wire logic signed [15:0] inductor_current,
    output logic [TRIP_N-1:0]       trip_out
);
    // Unclocked on purpose: the trip can move at any point in a cycle
    always_comb
    begin
        trip_out           = '0;
        trip_out[TRIP_BIT] = !(inductor_current > ZC_LEVEL);
    end
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb
    import zc_capture_pkg::*;
;
    localparam logic [31:0] PH  = 32'h0100;
    localparam int          DLY = 5;
    logic               mclk    = 1'b0;
    logic               sys_rst = 1'b1;
    logic               psel    = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite  = 1'b0;
    logic [ADDR_W-1:0]  paddr   = '0;
    logic [31:0]        pwdata  = '0;
    logic signed [15:0] current = 16'sh0064;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [TRIP_N-1:0]  trip;
    logic               sync_pulse;
    logic               filtered_event;
    logic [CNT_W-1:0]   time_base_counter;
    logic [31:0]        rd;
    logic               er;
    logic [CNT_W-1:0]   p0, p1, cap_b;
    int                 bad_count = 0, checks = 0, tick = 0;
    int                 hits, lat, sl, l0, t0, t_b;

    zero_cross_capture zero_cross_capture_i (
        .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .crossbar_trip_in(trip),
        .sync_pulse(sync_pulse), .filtered_event(filtered_event),
        .time_base_counter(time_base_counter));
    comparator_model comparator_model_i (
        .inductor_current(current), .trip_out(trip));

    always #12.5 mclk = !mclk;
    always @(posedge mclk) tick <= tick + 1;

////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, s);
        checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Software start; the filter is armed one edge after the access
    task automatic arm(input logic [31:0] extra);
        apb(1'b1, VALLEY_CTRL_OFS, 32'h2 | extra);
        repeat (2) @(posedge mclk);
    endtask

    // Current dips below zero and stays there for the whole window, so a
    // level-following filter would show more than one pulse
    task automatic fire();
        hits = 0;
        lat  = -1;
        sl   = -1;
        @(posedge mclk);
        t0 = tick;
        current <= -16'sh0014;
        for (int n = 0; n < 40; n++)
        begin
            @(posedge mclk);
            if (filtered_event === 1'b1)
            begin
                hits++;
                if (lat < 0)
                    lat = n;
            end
            if (sync_pulse === 1'b1 && sl < 0)
                sl = n;
            if (sl >= 0 && n == sl + 1)
                p0 = time_base_counter;
            if (sl >= 0 && n == sl + 2)
                p1 = time_base_counter;
        end
        current <= 16'sh0064;
        repeat (4) @(posedge mclk);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        apb(1'b0, PERIOD_OFS, '0);
        chk("period_rst", 32'hFFFF, rd);
        apb(1'b0, 12'h040, '0);
        chk("unmapped_err", 1, er);
        chk("unmapped_rd", 0, rd);
        apb(1'b0, STATUS_OFS, '0);
        chk("idle_rst", 0, rd);
        apb(1'b1, COMPARE_SEL_OFS, {26'h0, COND_HIGH, 4'h5});
        apb(1'b1, COMPARE_CTRL_OFS, 32'h3);
        apb(1'b1, PHASE_OFS, PH);
        apb(1'b1, TIME_BASE_CTL_OFS, 32'h1);
        arm(0);
        fire();
        chk("mux_off", 0, hits);
        apb(1'b1, CROSSBAR_EN_OFS, 32'h20);
        fire();
        chk("pulse_count", 1, hits);
        chk("sync_slot", lat + 1, sl);
        chk("phase_load", PH, p0);
        chk("count_on", PH + 1, p1);
        l0 = lat;
        fire();
        chk("no_rearm", 0, hits);
        apb(1'b1, TIME_BASE_CTL_OFS, 32'h0);
        arm(0);
        fire();
        chk("free_run", 16'(p0 + 16'h1), p1);
        chk("no_load", 1, p0 !== PH[15:0]);
        apb(1'b0, CAPTURE_OFS, '0);
        cap_b = rd[15:0];
        t_b = t0;
        apb(1'b1, COMPARE_CTRL_OFS, 32'h1);
        arm(0);
        fire();
        chk("sync_off", -1, sl);
        apb(1'b0, CAPTURE_OFS, '0);
        chk("cap_gap", 16'(t0 - t_b), 16'(rd[15:0] - cap_b));
        apb(1'b1, SW_DELAY_OFS, DLY);
        arm(32'h4);
        fire();
        chk("sw_delay", l0 + DLY, lat);
        apb(1'b1, FILTER_CTRL_OFS, 32'h2);
        apb(1'b1, BLANK_LENGTH_OFS, 32'hFFFF);
        arm(0);
        fire();
        chk("blanked", 0, hits);
        apb(1'b1, FILTER_CTRL_OFS, 32'h0);
        apb(1'b1, COMPARE_SEL_OFS, {26'h0, COND_OFF, 4'h5});
        arm(0);
        fire();
        chk("cond_off", 0, hits);
        apb(1'b1, FILTER_CTRL_OFS, 32'h1);
        arm(0);
        fire();
        chk("raw_source", 1, hits);
        apb(1'b1, FILTER_CTRL_OFS, 32'h0);
        apb(1'b1, COMPARE_SEL_OFS, {26'h0, COND_HIGH, 4'h5});
        apb(1'b1, COMPARE_CTRL_OFS, 32'h2);
        fire();
        chk("raw_sync", 1, sl);
        chk("idle_filter", 0, hits);
        apb(1'b1, COMPARE_CTRL_OFS, 32'h0);
        // Low condition: the event falls inside the loop and rises after it
        apb(1'b1, COMPARE_SEL_OFS, {26'h0, COND_LOW, 4'h5});
        arm(0);
        apb(1'b0, STATUS_OFS, '0);
        chk("armed", 1, rd);
        fire();
        chk("low_hold", 0, hits);
        apb(1'b0, STATUS_OFS, '0);
        chk("low_edge", 0, rd);
        results();
    end

    // About 620 cycles are needed; about five times that means a hang
    initial
    begin
        #80000;
        bad_count++;
        results();
    end
endmodule
